// >>> design/vss_pkg.sv
// Constants, states and helpers of the soft-start and voltage-select sequencer.
// Assumes one 50 MHz core clock; every slower rate comes from enable pulses.
package vss_pkg;

  localparam int CLK_HZ = 50_000_000;
  localparam int INT_HZ = 16_000_000;
  // Nearest whole divider: internal sampling runs a little fast
  localparam logic [1:0] DIV16_LAST = 2'(CLK_HZ / INT_HZ - 1);

  localparam int TRACK_STEP_NS = 4000;
  localparam int HALF_WAIT_NS  = TRACK_STEP_NS / 2;
  localparam int SS_STEP_NS    = 32000;
  localparam logic [10:0] TRACK_CYC = 11'(TRACK_STEP_NS * (CLK_HZ / 1_000_000) / 1000);
  localparam logic [10:0] HALF_CYC  = 11'(HALF_WAIT_NS * (CLK_HZ / 1_000_000) / 1000);
  localparam logic [10:0] SS_CYC    = 11'(SS_STEP_NS * (CLK_HZ / 1_000_000) / 1000);

  localparam logic [6:0] SS_DELAY_SW    = 7'h40;
  localparam logic [6:0] NOLOAD_WAIT_SW = 7'h02;
  localparam int SENSE_OFS_SW = 640;
  localparam int SENSE_OFS_MV = 100;
  localparam int STEP_UV      = 12_500;
  localparam logic [3:0] SENSE_OFS_STEPS = 4'(SENSE_OFS_MV * 1000 / STEP_UV);
  localparam logic [6:0] SENSE_DEC_SW = 7'(SENSE_OFS_SW / (SENSE_OFS_MV * 1000 / STEP_UV));

  localparam logic [5:0] NOLOAD_CODE = 6'h3F;

  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_LEVEL  = 4'h8;
  localparam logic [7:0] CTRL_RESET  = 8'h01;
  localparam int CTRL_EN_BIT  = 0;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_OK_BIT    = 4;
  localparam int ST_PHASE_BIT = 5;
  localparam int ST_OV_BIT    = 6;
  localparam int ST_OFSLV_BIT = 7;
  localparam int LV_REF_LSB   = 0;
  localparam int LV_VID_LSB   = 8;
  localparam int LV_OFS_LSB   = 16;

  typedef enum logic [2:0] {
    ST_OFF     = 3'h0,
    ST_DELAY   = 3'h1,
    ST_RAMP    = 3'h3,
    ST_RUN     = 3'h2,
    ST_NOLOAD  = 3'h6,
    ST_OVLATCH = 3'h7
  } vss_state_e;

  // One count toward the target, or none when equal
  function automatic logic [5:0] vssStepToward(input logic [5:0] cur, input logic [5:0] tgt);
    if (tgt > cur) begin
      return cur + 6'h01;
    end else if (tgt < cur) begin
      return cur - 6'h01;
    end
    return cur;
  endfunction

endpackage

// >>> design/vss_sync.sv
// Three-stage input synchroniser with an agreement filter.
// Assumes inputs are asynchronous; en paces the sampling rate.
module vss_sync
  import vss_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;

  // First stage feeds only the second
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end else if (en) begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q_r <= s3_r;
      end
    end
  end

  assign q = q_r;

endmodule // vss_sync

// >>> design/vss_top.sv
// Enable qualification, soft-start and voltage-select tracking sequencer.
// Assumes comparator and pin inputs are asynchronous; Wishbone is on core_clk.
// Behaviour
// [R01] Voltage-select code is sampled on three successive internal 16 MHz edges.
// [R02] After a code change, wait half a change cycle, then step one count.
// [R03] Cancel the pending step if the difference sign reverses during that wait.
// [R04] Larger differences are closed one count every 4 us.
// [R05] The processor should move the code one step at a time.
// [R06] Phase outputs stay high impedance in shutdown.
// [R07] Shutdown holds until supply-valid; falling supply-valid returns to it.
// [R08] Shutdown holds until the threshold-enable comparator reports high.
// [R09] A low logic-level enable keeps the block in shutdown.
// [R10] All-ones code means no load: shut down, restart on another code.
// [R11] Two switching cycles after no-load, raise trip level and disable phases.
// [R12] Overvoltage latch survives the no-load code and any code change.
// [R13] Overvoltage latch clears only by enable cycling or supply-valid loss.
// [R14] Soft-start begins at once when all enables hold and code valid.
// [R15] Soft-start ramps the reference linearly from zero to the code.
// [R16] Phases stay high impedance until the ramp reaches the pre-bias level.
// [R17] Soft-start waits 64 switching cycles, then steps every 32 us.
// [R18] Sense offset starts at 100 mV, decays to zero over 640 cycles.
// [R19] Output-ok rises only after soft-start with output in window.
// [R20] Output-ok is low in every shutdown and high after good soft-start.
// [R21] Reference is a six-bit count of 12.5 mV steps, counting up from zero.
// [R22] Code is synchronised first; switching cycles come from one oscillator tick.
//
// The Wishbone register port and the register addresses were decided locally.
module vss_top
  import vss_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  input  wire logic [3:0]  sel_i,
  input  wire logic        we_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  input  wire logic        supplyValid,
  input  wire logic        thresholdEnable,
  input  wire logic        logicLevelEnable,
  input  wire logic [5:0]  voltageSelectCode,
  input  wire logic        phaseOsc,
  input  wire logic        prebiasReached,
  input  wire logic        outputInWindow,
  input  wire logic        overvoltageTrip,
  output logic [5:0]       refCode,
  output logic             phaseOutEn,
  output logic             ovLevelShutdown,
  output logic [3:0]       senseOffset,
  output logic             outputOkFlagOut,
  output logic             outputOkFlagOe
);

  vss_state_e  state_r;
  vss_state_e  state_nxt;
  logic [5:0]  refCode_r;
  logic [5:0]  ref_nxt;
  logic [10:0] timer_r;
  logic [10:0] timer_nxt;
  logic [6:0]  swCnt_r;
  logic [6:0]  swCnt_nxt;
  logic [6:0]  ofsCnt_r;
  logic [6:0]  ofsCnt_nxt;
  logic [3:0]  senseOfs_r;
  logic [3:0]  ofs_nxt;
  logic        released_r;
  logic        released_nxt;
  logic        pend_r;
  logic        pend_nxt;
  logic        dirUp_r;
  logic        dirUp_nxt;
  logic [5:0]  vidPrev_r;
  logic        phaseEn_r;
  logic        ovLvl_r;
  logic        okFlag_r;
  logic        oscPrev_r;
  logic [1:0]  div_r;
  logic [7:0]  ctrl_r;
  logic        ack_r;
  logic [31:0] datO_r;

  logic [6:0]  pinS;
  logic [5:0]  vidS;
  wire         tick16 = (div_r == DIV16_LAST);
  wire         svS = pinS[0];
  wire         teS = pinS[1];
  wire         llS = pinS[2];
  wire         oscS = pinS[3];
  wire         prebiasS = pinS[4];
  wire         windowS = pinS[5];
  wire         ovS = pinS[6];
  wire         swTick = oscS & ~oscPrev_r;

  // [R07] [R08] [R09] qualifying enables
  wire condOk = svS & teS & llS & ctrl_r[CTRL_EN_BIT];
  // [R10] no-load code
  wire noLoad = (vidS == NOLOAD_CODE);
  wire startOk = condOk & ~noLoad;
  wire vidChanged = (vidS != vidPrev_r);
  wire sameSign = (vidS != refCode_r) && ((vidS > refCode_r) == dirUp_r);

  // [R22] pins and oscillator through the filter
  vss_sync #(.W(7)) u_pinSync (
    .core_clk (core_clk),
    .rst      (rst),
    .en       (1'h1),
    .d        ({overvoltageTrip, outputInWindow, prebiasReached, phaseOsc,
                logicLevelEnable, thresholdEnable, supplyValid}),
    .q        (pinS)
  );

  // [R01] code sampled on internal 16 MHz edges
  vss_sync #(.W(6)) u_vidSync (
    .core_clk (core_clk),
    .rst      (rst),
    .en       (tick16),
    .d        (voltageSelectCode),
    .q        (vidS)
  );

  always_comb begin
    state_nxt = state_r;
    // [R13] enable or supply loss clears the latch
    if (!condOk) begin
      state_nxt = ST_OFF;
    end else if (ovS && state_r != ST_OFF) begin
      state_nxt = ST_OVLATCH;
    end else begin
      case (state_r)
        // [R14] immediate start
        ST_OFF: begin
          if (!noLoad) state_nxt = ST_DELAY;
        end
        ST_DELAY: begin
          if (noLoad) begin
            state_nxt = ST_NOLOAD;
          end else if (swTick && swCnt_r == SS_DELAY_SW - 7'h01) begin
            state_nxt = ST_RAMP;
          end
        end
        ST_RAMP: begin
          if (noLoad) begin
            state_nxt = ST_NOLOAD;
          end else if (refCode_r == vidS) begin
            state_nxt = ST_RUN;
          end
        end
        ST_RUN: begin
          if (noLoad) state_nxt = ST_NOLOAD;
        end
        // [R11] two switching cycles before shutdown
        ST_NOLOAD: begin
          if (swTick && swCnt_r == NOLOAD_WAIT_SW - 7'h01) state_nxt = ST_OFF;
        end
        // [R12] codes cannot leave the latch
        ST_OVLATCH: state_nxt = ST_OVLATCH;
        default: state_nxt = ST_OFF;
      endcase
    end
  end

  always_comb begin
    ref_nxt      = refCode_r;
    timer_nxt    = timer_r;
    swCnt_nxt    = swCnt_r;
    ofsCnt_nxt   = ofsCnt_r;
    ofs_nxt      = senseOfs_r;
    released_nxt = released_r;
    pend_nxt     = pend_r;
    dirUp_nxt    = dirUp_r;
    if (state_nxt != state_r) begin
      swCnt_nxt = 7'h00;
      timer_nxt = SS_CYC - 11'h001;
      pend_nxt  = 1'h0;
    end else if (swTick) begin
      swCnt_nxt = swCnt_r + 7'h01;
    end
    if (state_nxt == ST_OFF || state_nxt == ST_OVLATCH) begin
      ref_nxt      = 6'h00;
      ofs_nxt      = 4'h0;
      released_nxt = 1'h0;
    end else if (state_nxt == ST_DELAY) begin
      // [R18] full offset at start
      ofs_nxt    = SENSE_OFS_STEPS;
      ofsCnt_nxt = 7'h00;
      ref_nxt    = 6'h00;
    end else begin
      // [R18] one count off every 80 cycles
      if (swTick && senseOfs_r != 4'h0) begin
        if (ofsCnt_r == SENSE_DEC_SW - 7'h01) begin
          ofsCnt_nxt = 7'h00;
          ofs_nxt    = senseOfs_r - 4'h1;
        end else begin
          ofsCnt_nxt = ofsCnt_r + 7'h01;
        end
      end
      // [R16] release at pre-bias level
      if (state_r == ST_RAMP && prebiasS) released_nxt = 1'h1;
      // [R15] [R17] [R21] linear ramp
      if (state_r == ST_RAMP && state_nxt == ST_RAMP) begin
        if (timer_r == 11'h000) begin
          ref_nxt   = vssStepToward(refCode_r, vidS);
          timer_nxt = SS_CYC - 11'h001;
        end else begin
          timer_nxt = timer_r - 11'h001;
        end
      end
      if (state_r == ST_RUN && state_nxt == ST_RUN) begin
        // [R02] half-cycle wait on change
        if (vidChanged) begin
          pend_nxt  = 1'h1;
          dirUp_nxt = (vidS > refCode_r);
          timer_nxt = HALF_CYC - 11'h001;
        end else if (pend_r) begin
          if (timer_r != 11'h000) begin
            timer_nxt = timer_r - 11'h001;
          // [R03] [R04] step or cancel
          end else if (sameSign) begin
            ref_nxt   = vssStepToward(refCode_r, vidS);
            timer_nxt = TRACK_CYC - 11'h001;
          end else begin
            pend_nxt = 1'h0;
          end
        end
      end
    end
  end

  // [R06] [R16] phases driven in run, in ramp once released, and held through no-load
  // No-load keeps phases as they were, so a cut delay never drives them
  wire phaseEn_nxt = (state_nxt == ST_RUN) || (state_nxt == ST_NOLOAD && phaseEn_r) ||
                     (state_nxt == ST_RAMP && released_nxt);
  // [R19] [R20] ok only in run with output in window
  wire okFlag_nxt = (state_nxt == ST_RUN) && windowS;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r    <= ST_OFF;
      refCode_r  <= 6'h00;
      timer_r    <= 11'h000;
      swCnt_r    <= 7'h00;
      ofsCnt_r   <= 7'h00;
      senseOfs_r <= 4'h0;
      released_r <= 1'h0;
      pend_r     <= 1'h0;
      dirUp_r    <= 1'h0;
      vidPrev_r  <= 6'h00;
      phaseEn_r  <= 1'h0;
      ovLvl_r    <= 1'h1;
      okFlag_r   <= 1'h0;
      oscPrev_r  <= 1'h0;
      div_r      <= 2'h0;
    end else begin
      state_r    <= state_nxt;
      refCode_r  <= ref_nxt;
      timer_r    <= timer_nxt;
      swCnt_r    <= swCnt_nxt;
      ofsCnt_r   <= ofsCnt_nxt;
      senseOfs_r <= ofs_nxt;
      released_r <= released_nxt;
      pend_r     <= pend_nxt;
      dirUp_r    <= dirUp_nxt;
      vidPrev_r  <= vidS;
      phaseEn_r  <= phaseEn_nxt;
      ovLvl_r    <= (state_nxt == ST_OFF);
      okFlag_r   <= okFlag_nxt;
      oscPrev_r  <= oscS;
      div_r      <= tick16 ? 2'h0 : div_r + 2'h1;
    end
  end

  // Register slave: one wait state, write lands on the acked edge
  wire busHit = cyc_i & stb_i;
  wire [31:0] statusWord = {24'h00_0000, ovLvl_r, (state_r == ST_OVLATCH), phaseEn_r,
                            okFlag_r, 1'h0, state_r};
  wire [31:0] levelWord = {12'h000, senseOfs_r, 2'h0, vidS, 2'h0, refCode_r};
  wire [31:0] rdData = (adr_i == ADDR_CTRL)   ? {24'h00_0000, ctrl_r} :
                       (adr_i == ADDR_STATUS) ? statusWord :
                       (adr_i == ADDR_LEVEL)  ? levelWord : 32'h0000_0000;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_r  <= 1'h0;
      datO_r <= 32'h0000_0000;
      ctrl_r <= CTRL_RESET;
    end else begin
      ack_r <= busHit & ~ack_r;
      if (busHit && !ack_r) datO_r <= rdData;
      if (busHit && ack_r && we_i && adr_i == ADDR_CTRL && sel_i[0]) ctrl_r <= dat_i[7:0];
    end
  end

  assign dat_o           = datO_r;
  assign ack_o           = ack_r;
  assign refCode         = refCode_r;
  assign phaseOutEn      = phaseEn_r;
  assign ovLevelShutdown = ovLvl_r;
  assign senseOffset     = senseOfs_r;
  // Open drain: pull low unless the flag is up
  assign outputOkFlagOut = 1'h0;
  assign outputOkFlagOe  = ~okFlag_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_stepOne;
    (state_r == ST_RUN && $past(state_r) == ST_RUN && refCode_r != $past(refCode_r)) |->
      (refCode_r == $past(refCode_r) + 6'h01 || refCode_r == $past(refCode_r) - 6'h01);
  endproperty
  a_stepOne: assert property (p_stepOne) else $error("Tracking moved more than one count"); // R02

  property p_cancel;
    (state_r == ST_RUN && state_nxt == ST_RUN && pend_r && timer_r == 11'h000 &&
     !vidChanged && !sameSign) |=> (refCode_r == $past(refCode_r)) && !pend_r;
  endproperty
  a_cancel: assert property (p_cancel) else $error("Reversed step not cancelled"); // R03

  property p_shutHiZ;
    (state_r == ST_OFF || state_r == ST_OVLATCH) |-> !phaseOutEn && !okFlag_r;
  endproperty
  a_shutHiZ: assert property (p_shutHiZ) else $error("Phases driven in shutdown"); // R06

  property p_svGate;
    !svS |=> state_r == ST_OFF;
  endproperty
  a_svGate: assert property (p_svGate) else $error("Running without supply-valid"); // R07

  property p_teGate;
    !teS |=> state_r == ST_OFF && ovLevelShutdown;
  endproperty
  a_teGate: assert property (p_teGate) else $error("Running without threshold enable"); // R08

  property p_llGate;
    !llS |=> state_r == ST_OFF && refCode_r == 6'h00;
  endproperty
  a_llGate: assert property (p_llGate) else $error("Running without logic enable"); // R09

  property p_noLoad;
    (state_r == ST_RUN && noLoad && condOk && !ovS) |=> state_r == ST_NOLOAD;
  endproperty
  a_noLoad: assert property (p_noLoad) else $error("No-load code ignored"); // R10

  property p_noLoadWait;
    $rose(state_r == ST_NOLOAD) |-> phaseOutEn == $past(phaseOutEn) && !ovLevelShutdown;
  endproperty
  a_noLoadWait: assert property (p_noLoadWait) else $error("No-load shut down early"); // R11

  property p_ovHold;
    (state_r == ST_OVLATCH && condOk) |=> state_r == ST_OVLATCH;
  endproperty
  a_ovHold: assert property (p_ovHold) else $error("Overvoltage latch released"); // R12

  property p_start;
    (state_r == ST_OFF && startOk) |=> state_r == ST_DELAY && senseOffset == SENSE_OFS_STEPS;
  endproperty
  a_start: assert property (p_start) else $error("Soft-start not begun"); // R14

  property p_prebias;
    (state_r == ST_RAMP && !released_r) |-> !phaseOutEn && senseOfs_r <= SENSE_OFS_STEPS;
  endproperty
  a_prebias: assert property (p_prebias) else $error("Phases released before pre-bias"); // R16

  property p_delayRef;
    state_r == ST_DELAY |-> refCode_r == 6'h00 && senseOfs_r == SENSE_OFS_STEPS;
  endproperty
  a_delayRef: assert property (p_delayRef) else $error("Reference moved during delay"); // R17

  property p_okRun;
    okFlag_r |-> state_r == ST_RUN && !outputOkFlagOe;
  endproperty
  a_okRun: assert property (p_okRun) else $error("Output-ok outside run"); // R19

endmodule // vss_top

// >>> sim/vss_cpu_model.sv
// Processor model that drives the voltage-select code.
// Assumes core_clk at 50 MHz; the bench sets target and jump.
module vss_cpu_model
  import vss_pkg::*;
#(
  // Must match the bench's first target
  parameter logic [5:0] START_CODE = 6'h04
) (
  input  wire logic       coreClk,
  input  wire logic       rst,
  input  wire logic [5:0] target,
  input  wire logic       jump,
  output logic      [5:0] code
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [10:0] paceCnt;
  logic        paceEnd;

  assign paceEnd = (paceCnt == TRACK_CYC - 11'h001);

  always_ff @(posedge coreClk or posedge rst) begin
    if (rst) begin
      paceCnt <= 11'h000;
      code    <= START_CODE;
    end else begin
      paceCnt <= paceEnd ? 11'h000 : paceCnt + 11'h001;
      // Jump straight to the target whenever jump is high, whatever the size of the change
      if (jump) begin
        code <= target;
      end else if (paceEnd && target > code) begin
        code <= code + 6'h01;
      end else if (paceEnd && target < code) begin
        code <= code - 6'h01;
      end
    end
  end
endmodule // vss_cpu_model

// >>> sim/vss_top_test.sv
// Self-checking bench for the soft-start and voltage-select sequencer.
// Assumes the processor model is compiled first; phase ticks every 8 clocks.
module vss_top_test
  import vss_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic        coreClk, rst, weI, cycI, stbI, ackO, jump;
  logic        prebias, inWin, ovTrip, osc, phaseEn, ovLvl, okOut, okOe, seen3;
  logic [3:0]  adrI, selI, senseOfs;
  logic [31:0] datI, datO, rd;
  logic [2:0]  ens, oscCnt;
  logic [5:0]  target, code, refCode;
  int          badCount, checksDone, n;

  vss_cpu_model cpu (.coreClk(coreClk), .rst(rst), .target(target), .jump(jump), .code(code));
  vss_top DUT (.core_clk(coreClk), .rst(rst), .adr_i(adrI), .dat_i(datI), .dat_o(datO),
    .sel_i(selI), .we_i(weI), .cyc_i(cycI), .stb_i(stbI), .ack_o(ackO),
    .supplyValid(ens[0]), .thresholdEnable(ens[1]), .logicLevelEnable(ens[2]),
    .voltageSelectCode(code), .phaseOsc(osc), .prebiasReached(prebias),
    .outputInWindow(inWin), .overvoltageTrip(ovTrip), .refCode(refCode),
    .phaseOutEn(phaseEn), .ovLevelShutdown(ovLvl), .senseOffset(senseOfs),
    .outputOkFlagOut(okOut), .outputOkFlagOe(okOe));

  initial begin
    coreClk = 1'b0;
    forever #10 coreClk = ~coreClk;
  end

  // Fast switching clock keeps the 64-cycle delay short
  always @(posedge coreClk) begin
    oscCnt <= oscCnt + 3'h1;
    osc    <= oscCnt[2];
  end

  task automatic summarize();
    if (badCount == 0 && checksDone > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checksDone++;
    if (s !== e) begin
      badCount++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  task automatic fail();
    badCount++;
    $display("mismatch at %0t: wait ran out", $time);
    summarize();
  endtask

  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int k;
    adrI <= a;
    weI  <= w;
    datI <= d;
    cycI <= 1'b1;
    stbI <= 1'b1;
    k = 0;
    do begin
      @(posedge coreClk);
      k++;
      if (k > 20) fail();
    end while (ackO !== 1'b1);
    rd = datO;
    cycI <= 1'b0;
    stbI <= 1'b0;
    @(posedge coreClk);
  endtask

  task automatic chkSt(input logic [2:0] s);
    wb(ADDR_STATUS, 1'b0, 32'h0);
    check(rd[2:0], s);
  endtask

  // Selector instead of a reference: both values are port-driven
  task automatic waitFor(input logic useCode, input logic [5:0] v, input int lim);
    n = 0;
    while ((useCode ? code : refCode) !== v) begin
      @(posedge coreClk);
      n++;
      if (n > lim) fail();
    end
  endtask

  task automatic tReset();
    check(refCode, 6'h00); // from zero
    check(phaseEn, 1'b0); // hi-z
    check(okOe, 1'b1); // pulled low
    check(okOut, 1'b0); // open drain
    check(ovLvl, 1'b1); // trip level
    wb(ADDR_CTRL, 1'b0, 32'h0);
    check(rd[7:0], CTRL_RESET);
    wb(4'hC, 1'b0, 32'h0);
    check(rd, 32'h0);
  endtask

  task automatic tGate();
    for (int i = 0; i < 3; i++) begin
      ens <= 3'h7 ^ (3'h1 << i);
      repeat (40) @(posedge coreClk);
      chkSt(ST_OFF); // held off
      check(phaseEn, 1'b0); // hi-z
    end
    ens <= 3'h7;
    repeat (12) @(posedge coreClk);
    chkSt(ST_DELAY); // starts
    check(senseOfs, SENSE_OFS_STEPS); // full offset
    check(okOe, 1'b1); // still low
  endtask

  task automatic tStart();
    repeat (460) @(posedge coreClk);
    chkSt(ST_DELAY); // still waiting
    check(refCode, 6'h00); // no ramp yet
    waitFor(1'b0, 6'h01, 1800);
    waitFor(1'b0, 6'h02, 1700);
    check(32'(n >= 1598 && n <= 1602), 32'h1); // pace
    check(32'(senseOfs inside {[1:7]}), 32'h1); // decaying
    check(phaseEn, 1'b0); // below prebias
    check(okOe, 1'b1); // not yet
    prebias <= 1'b1;
    repeat (8) @(posedge coreClk);
    check(phaseEn, 1'b1); // released
    waitFor(1'b0, 6'h04, 3500);
    repeat (4) @(posedge coreClk);
    chkSt(ST_RUN); // reached code
    check(okOe, 1'b0); // released
    inWin <= 1'b0;
    repeat (8) @(posedge coreClk);
    check(okOe, 1'b1); // window lost
    inWin <= 1'b1;
  endtask

  task automatic tTrack();
    check(senseOfs, 4'h0); // fully decayed
    target <= 6'h05;
    waitFor(1'b1, 6'h05, 400);
    waitFor(1'b0, 6'h05, 300);
    check(32'(n >= 100 && n <= 130), 32'h1); // half wait
    jump   <= 1'b1;
    target <= 6'h02;
    waitFor(1'b0, 6'h04, 400);
    waitFor(1'b0, 6'h03, 300);
    check(32'(n >= 198 && n <= 202), 32'h1); // 4 us pace
    waitFor(1'b0, 6'h02, 300);
    check(32'(n >= 198 && n <= 202), 32'h1); // 4 us pace
    repeat (300) @(posedge coreClk);
    target <= 6'h03;
    repeat (30) @(posedge coreClk);
    target <= 6'h01;
    seen3 = 1'b0;
    repeat (600) begin
      @(posedge coreClk);
      seen3 = seen3 | (refCode === 6'h03);
    end
    check(seen3, 1'b0); // cancelled
    check(refCode, 6'h01); // single step
  endtask

  task automatic tNoLoad();
    target <= NOLOAD_CODE;
    n = 0;
    while (ovLvl !== 1'b1 && n < 100) begin
      @(posedge coreClk);
      n++;
    end
    check(32'(n >= 14 && n <= 40), 32'h1); // two cycles
    check(phaseEn, 1'b0); // hi-z
    chkSt(ST_OFF); // shut down
    check(okOe, 1'b1); // pulled low
    target <= 6'h04;
    repeat (20) @(posedge coreClk);
    chkSt(ST_DELAY); // restarts
    waitFor(1'b0, 6'h04, 8000);
  endtask

  task automatic tOv();
    ovTrip <= 1'b1;
    repeat (8) @(posedge coreClk);
    ovTrip <= 1'b0;
    chkSt(ST_OVLATCH); // latched
    target <= NOLOAD_CODE;
    repeat (60) @(posedge coreClk);
    chkSt(ST_OVLATCH); // no-load ignored
    target <= 6'h05;
    repeat (60) @(posedge coreClk);
    chkSt(ST_OVLATCH); // code ignored
    ens <= 3'h3;
    repeat (12) @(posedge coreClk);
    chkSt(ST_OFF); // enable cycled
    check(okOe, 1'b1); // pulled low
    ens <= 3'h7;
    repeat (12) @(posedge coreClk);
    chkSt(ST_DELAY); // cleared
    ens <= 3'h6;
    repeat (12) @(posedge coreClk);
    chkSt(ST_OFF); // supply lost
    ens <= 3'h7;
    wb(ADDR_CTRL, 1'b1, 32'h0);
    repeat (12) @(posedge coreClk);
    chkSt(ST_OFF);
  endtask

  initial begin
    rst        = 1'b1;
    ens        = 3'h0;
    target     = 6'h04;
    jump       = 1'b0;
    adrI       = 4'h0;
    datI       = 32'h0;
    selI       = 4'h1;
    weI        = 1'b0;
    cycI       = 1'b0;
    stbI       = 1'b0;
    prebias    = 1'b0;
    inWin      = 1'b1;
    ovTrip     = 1'b0;
    oscCnt     = 3'h0;
    osc        = 1'b0;
    badCount   = 0;
    checksDone = 0;
    repeat (10) @(posedge coreClk);
    rst <= 1'b0;
    @(posedge coreClk);
    tReset();
    tGate();
    tStart();
    tTrack();
    tNoLoad();
    tOv();
    summarize();
  end
endmodule // vss_top_test
